// ---- design/sbw_defs.svh ----
// timing and layout constants for the byte-masked burst sram write path
`ifndef SBW_DEFS_SVH
`define SBW_DEFS_SVH
`define SBW_LANE_W 9
`define SBW_ADDR_W 8
`define SBW_DEPTH 256
`define SBW_BURST_STEP 8'h01
`endif

// ---- design/sbw_pkg.sv ----
// types for the byte-masked burst sram write path
package sbw_pkg;
  typedef enum logic [1:0] {
    SBW_IDLE = 2'b00,
    SBW_WAIT = 2'b01,
    SBW_WR0 = 2'b10,
    SBW_WR1 = 2'b11
  } sbw_state_e;
  typedef struct packed {
    logic load_cmd_n;
    logic read_not_write;
  } sbw_cmd_s;
endpackage : sbw_pkg

// ---- design/sbw_sram_core.sv ----
// double-data-rate burst sram core with per-lane byte write masking
`include "sbw_defs.svh"

// Overview of operation
// - 18-bit: select 0 gates 8:0, 1 gates 17:9
// - 18-bit: all selects high leaves word unchanged
// - 36-bit: four selects gate four 9-bit lanes
// - 36-bit: all selects high writes nothing
// - selects sampled and applied per beat
// - data taken and driven on both clock phases
// - reset leaves it deselected, rd_data_oe low and rd_data zero
// - first beat at address A, second A+1
// - beats taken at the next positive-clock rise and the negative rise after it
module sbw_sram_core
  import sbw_pkg::*;
#(
  parameter int LANES = 2
)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_phase_n,
  input wire logic load_cmd_n,
  input wire logic read_not_write,
  input wire logic [`SBW_ADDR_W-1:0] addr,
  input wire logic [LANES*`SBW_LANE_W-1:0] wr_data,
  input wire logic [LANES-1:0] byte_write_select_n,
  output logic [LANES*`SBW_LANE_W-1:0] rd_data,
  output logic rd_data_oe
);
  localparam int DW = LANES * `SBW_LANE_W;

  // sys_clk runs at twice the device clock; clk_phase_n marks the negative-clock half
  // the array is not cleared by reset, so unwritten words stay unknown
  logic [DW-1:0] mem [0:`SBW_DEPTH-1];

  // write burst sequencer state
  sbw_state_e wr_state_ff;
  sbw_state_e nxt_wr_state;

  // a new write loaded during beat 0 of the previous one
  logic wr_again_ff;
  logic nxt_wr_again;

  // address loaded with the write command
  logic [`SBW_ADDR_W-1:0] wr_base_ff;

  // first-beat address kept for the second beat
  logic [`SBW_ADDR_W-1:0] wr_hold_ff;

  // read burst pipeline
  logic [`SBW_ADDR_W-1:0] rd_base_ff;
  logic rd_first_ff;
  logic rd_second_ff;

  // output registers
  logic [DW-1:0] rd_data_ff;
  logic rd_data_oe_ff;

  sbw_cmd_s cmd;

  assign cmd = {load_cmd_n, read_not_write};

  // ------------------------------------------------------------------
  // command decode
  // ------------------------------------------------------------------

  // commands are taken only on the positive-clock rise
  wire cmd_edge = !clk_phase_n;
  wire load_now = cmd_edge && !cmd.load_cmd_n;
  wire start_wr = load_now && !cmd.read_not_write;
  wire start_rd = load_now && cmd.read_not_write;

  // ------------------------------------------------------------------
  // write beats
  // ------------------------------------------------------------------

  // beat 0 one positive rise after the command, beat 1 on the next negative rise
  wire in_beat0 = (wr_state_ff == SBW_WR0);
  wire in_beat1 = (wr_state_ff == SBW_WR1);
  wire beat0 = in_beat0 && !clk_phase_n;
  wire beat1 = in_beat1 && clk_phase_n;
  wire beat_any = beat0 || beat1;

  // second beat goes to the next location of the burst
  wire [`SBW_ADDR_W-1:0] wr_next_addr = `SBW_ADDR_W'(wr_hold_ff + `SBW_BURST_STEP);

  // first beat goes to the address loaded with the command
  wire [`SBW_ADDR_W-1:0] beat_addr = beat1 ? wr_next_addr : wr_base_ff;

  wire [DW-1:0] old_word = mem[beat_addr];
  wire [DW-1:0] merged;
  wire [LANES-1:0] lane_keep;

  // each active-low select keeps or replaces its own 9-bit lane for this beat only
  genvar g;
  generate
    for (g = 0; g < LANES; g++)
    begin : g_lane
      // the select is sampled with the beat it qualifies
      assign lane_keep[g] = byte_write_select_n[g];
      assign merged[g*`SBW_LANE_W +: `SBW_LANE_W] = lane_keep[g] ?
        old_word[g*`SBW_LANE_W +: `SBW_LANE_W] :
        wr_data[g*`SBW_LANE_W +: `SBW_LANE_W];
    end
  endgenerate

  // all selects high: nothing written this beat
  wire none_selected = &lane_keep;
  wire do_write = beat_any && !none_selected;

  // ------------------------------------------------------------------
  // write sequencer
  // ------------------------------------------------------------------

  always_comb
  begin
    nxt_wr_state = wr_state_ff;
    nxt_wr_again = wr_again_ff;
    case (wr_state_ff)
      SBW_IDLE:
      begin
        nxt_wr_again = 1'b0;
        if (start_wr)
          nxt_wr_state = SBW_WAIT;
      end
      SBW_WAIT:
      begin
        nxt_wr_again = 1'b0;
        nxt_wr_state = SBW_WR0;
      end
      SBW_WR0:
      begin
        // a write loaded here has its first beat right after our second
        nxt_wr_again = start_wr;
        nxt_wr_state = SBW_WR1;
      end
      SBW_WR1:
      begin
        nxt_wr_again = 1'b0;
        if (wr_again_ff)
          nxt_wr_state = SBW_WR0;
        else
          nxt_wr_state = SBW_IDLE;
      end
      default:
      begin
        nxt_wr_again = 1'b0;
        nxt_wr_state = SBW_IDLE;
      end
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      wr_state_ff <= SBW_IDLE;
      wr_again_ff <= 1'b0;
    end
    else
    begin
      wr_state_ff <= nxt_wr_state;
      wr_again_ff <= nxt_wr_again;
    end
  end

  // address of the burst being loaded
  always_ff @(posedge sys_clk)
  begin
    if (start_wr)
      wr_base_ff <= addr;
  end

  // a back-to-back command reloads wr_base_ff while beat 1 still needs the old one
  always_ff @(posedge sys_clk)
  begin
    if (beat0)
      wr_hold_ff <= wr_base_ff;
  end

  // array update, one word per data beat
  always_ff @(posedge sys_clk)
  begin
    if (do_write)
      mem[beat_addr] <= merged;
  end

  // ------------------------------------------------------------------
  // read burst
  // ------------------------------------------------------------------

  always_ff @(posedge sys_clk)
  begin
    if (start_rd)
      rd_base_ff <= addr;
  end

  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
    begin
      rd_first_ff <= 1'b0;
      rd_second_ff <= 1'b0;
    end
    else
    begin
      rd_first_ff <= start_rd;
      rd_second_ff <= rd_first_ff;
    end
  end

  wire rd_beat = rd_first_ff || rd_second_ff;
  wire [`SBW_ADDR_W-1:0] rd_next_addr = `SBW_ADDR_W'(rd_base_ff + `SBW_BURST_STEP);
  wire [`SBW_ADDR_W-1:0] rd_addr = rd_second_ff ? rd_next_addr : rd_base_ff;
  wire [DW-1:0] rd_word = mem[rd_addr];

  // ------------------------------------------------------------------
  // outputs
  // ------------------------------------------------------------------

  // outputs stay off until a read is issued
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rd_data_oe_ff <= 1'b0;
    else
      rd_data_oe_ff <= rd_beat;
  end

  // one word on each clock phase of the burst, zero while not driving
  always_ff @(posedge sys_clk)
  begin
    if (sys_rst)
      rd_data_ff <= '0;
    else if (rd_beat)
      rd_data_ff <= rd_word;
    else
      rd_data_ff <= '0;
  end

  assign rd_data = rd_data_ff;
  assign rd_data_oe = rd_data_oe_ff;
endmodule : sbw_sram_core

// ---- tb/sbw_core_sva.sv ----
// assertions on the read outputs of the burst sram core
`include "sbw_defs.svh"
module sbw_core_sva #(parameter int LANES = 2)
(
  input wire logic sys_clk,
  input wire logic sys_rst,
  input wire logic clk_phase_n,
  input wire logic load_cmd_n,
  input wire logic read_not_write,
  input wire logic [LANES*`SBW_LANE_W-1:0] rd_data,
  input wire logic rd_data_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (sys_rst);
  wire rc = !load_cmd_n && read_not_write && !clk_phase_n;
  wire q = rd_data_oe;
  chk_idle_zero: assert property (!q |-> rd_data == '0) else $error("idle data");
  chk_rst_quiet: assert property (disable iff (0) sys_rst |=> !q) else $error("rst oe");
  chk_rst_zero: assert property (disable iff (0) sys_rst |=> rd_data == '0) else $error("rst");
  chk_two_beats: assert property ($rose(q) |=> q ##1 !q) else $error("beats");
  chk_read_ans: assert property (rc && !q |-> ##[1:3] q) else $error("no read");
  chk_oe_cause: assert property ($rose(q) |->
    $past(rc) || $past(rc, 2) || $past(rc, 3)) else $error("cause");
  chk_nop_quiet: assert property (!q && load_cmd_n && $past(load_cmd_n) &&
    $past(load_cmd_n, 2) |=> !q) else $error("nop");
  chk_wr_silent: assert property (!load_cmd_n && !read_not_write && !q &&
    $past(load_cmd_n, 2) |=> !q [*3]) else $error("write oe");
  cover property (rc);
  cover property (!load_cmd_n && !read_not_write && !clk_phase_n);
  cover property ($rose(q));
endmodule : sbw_core_sva
bind sbw_sram_core sbw_core_sva #(.LANES(LANES)) chk (.*);

// ---- tb/sbw_ctl_model.sv ----
// memory controller model issuing write and read bursts
module sbw_ctl_model
  import sbw_pkg::*;
(
  input wire logic sys_clk,
  input wire logic [35:0] rd_data,
  input wire logic rd_data_oe,
  output logic ph_n,
  output sbw_cmd_s cmd,
  output logic [7:0] addr,
  output logic [35:0] wd,
  output logic [3:0] bws_n
);
  timeunit 1ns;
  timeprecision 1ns;
  initial {ph_n, cmd, addr, wd, bws_n} = {3'b010, 44'h0, 4'hF};
  // the phase runs on without pause, so the clocks are never stopped low
  always @(negedge sys_clk) ph_n <= ~ph_n;
  task automatic go(input logic rnw, input logic [7:0] a);
    do @(negedge sys_clk); while (ph_n !== 1'b1);
    cmd = '{1'b0, rnw};
    addr = a;
    @(negedge sys_clk) cmd.load_cmd_n = 1'b1;
    addr = ~a;
  endtask : go
  task automatic wr(input logic [7:0] a, input logic [71:0] d, input logic [7:0] m);
    go(1'b0, a);
    @(negedge sys_clk) {wd, bws_n} = {d[35:0], m[3:0]};
    @(negedge sys_clk) {wd, bws_n} = {d[71:36], m[7:4]};
    @(negedge sys_clk) {wd, bws_n} = {~wd, 4'hF};
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [71:0] q, output int n);
    n = 0;
    go(1'b1, a);
    repeat (8)
    begin
      @(negedge sys_clk);
      if (rd_data_oe === 1'b1) q = {rd_data, q[71:36]};
      n += int'(rd_data_oe === 1'b1);
    end
  endtask : rd
endmodule : sbw_ctl_model

// ---- tb/sbw_sram_core_tb.sv ----
// random and corner write bursts with lane masks, read back and compared
module sbw_sram_core_tb
  import sbw_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  `define CHK(s, e, g) comparisons++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %h saw %h", s, e, g); end
  logic sys_clk = 1'b0;
  logic sys_rst = 1'b1;
  logic ph_n, rd_data_oe;
  sbw_cmd_s cmd;
  logic [7:0] addr, a, m;
  logic [3:0] bws_n;
  logic [35:0] wd, rd_data, mem [256];
  logic [71:0] d, q;
  logic [17:0] rd_data2;
  logic oe2;
  logic [35:0] q2;
  int n_fail = 0, comparisons = 0, cyc = 0, seed = 9932, n;
  always #50 sys_clk = ~sys_clk;
  always @(posedge sys_clk)
  begin
    cyc++;
    if (cyc == 5000) wrap_up(1);
  end
  sbw_sram_core #(.LANES(4)) uut (.sys_clk(sys_clk), .sys_rst(sys_rst), .clk_phase_n(ph_n),
    .load_cmd_n(cmd.load_cmd_n), .read_not_write(cmd.read_not_write), .addr(addr),
    .wr_data(wd), .byte_write_select_n(bws_n), .rd_data(rd_data), .rd_data_oe(rd_data_oe));
  sbw_ctl_model ctl (.sys_clk(sys_clk), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
    .ph_n(ph_n), .cmd(cmd), .addr(addr), .wd(wd), .bws_n(bws_n));
  // narrow variant sees the two low lanes of the same bursts
  sbw_sram_core #(.LANES(2)) uut_narrow (.sys_clk(sys_clk), .sys_rst(sys_rst),
    .clk_phase_n(ph_n), .load_cmd_n(cmd.load_cmd_n), .read_not_write(cmd.read_not_write),
    .addr(addr), .wr_data(wd[17:0]), .byte_write_select_n(bws_n[1:0]), .rd_data(rd_data2),
    .rd_data_oe(oe2));
  always @(negedge sys_clk) if (oe2 === 1'b1) q2 <= {rd_data2, q2[35:18]};
  function automatic logic [35:0] mrg(input logic [35:0] o, w, input logic [3:0] s);
    for (int i = 0; i < 4; i++) if (!s[i]) o[9*i+:9] = w[9*i+:9];
    return o;
  endfunction : mrg
  task automatic wrap_up(input int t);
    n_fail += t;
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : wrap_up
  initial
  begin
    repeat (16) @(negedge sys_clk);
    sys_rst = 1'b0;
    `CHK("idle", 37'h0, {rd_data_oe, rd_data})
    for (int k = 0; k < 52; k++)
    begin
      // first nine bursts fill 20..31 fully, so later bursts meet no unknown lanes
      a = k < 9 ? 8'(32'h20 + 2 * k) : k < 12 ? 8'h10 : {4'h2, 4'($random(seed))};
      m = k < 10 ? 8'h00 : k == 10 ? 8'hFF : k == 11 ? 8'h5A : 8'($random(seed));
      d = 72'({$random(seed), $random(seed), $random(seed)});
      ctl.wr(a, d, m);
      mem[a] = mrg(mem[a], d[35:0], m[3:0]);
      mem[a+8'h01] = mrg(mem[a+8'h01], d[71:36], m[7:4]);
      ctl.rd(a, q, n);
      `CHK("beats", 2, n)
      `CHK("beat0", mem[a], q[35:0])
      `CHK("beat1", mem[a+8'h01], q[71:36])
      `CHK("defined", 1'b1, ^q !== 1'bx)
      `CHK("narrow", {mem[a+8'h01][17:0], mem[a][17:0]}, q2)
    end
    wrap_up(0);
  end
endmodule : sbw_sram_core_tb
